// ### shared/smpc_consts.svh
`ifndef SMPC_CONSTS_SVH
`define SMPC_CONSTS_SVH
// sleep control register layout
`define SMPC_SCR_ARM_BIT 0
`define SMPC_SCR_MODE_LSB 1
`define SMPC_SCR_MODE_MSB 2
`define SMPC_SCR_RESET 8'h00
// mcu control register layout
`define SMPC_MCR_BOFF_BIT 6
`define SMPC_MCR_UNLOCK_BIT 5
`define SMPC_MCR_RESET 8'h00
// mode codes
`define SMPC_MODE_IDLE 2'h0
`define SMPC_MODE_NOISE 2'h1
`define SMPC_MODE_PDOWN 2'h2
`define SMPC_MODE_RSVD 2'h3
// timed sequence windows in clock cycles
`define SMPC_UNLOCK_WINDOW 4
`define SMPC_BOFF_DELAY 3
`define SMPC_BOFF_LIFE 3
// halt after wake in clock cycles
`define SMPC_WAKE_HALT 4
// default start-up counts
`define SMPC_START_CYCLES 16
`define SMPC_RESET_CYCLES 64
`endif

// ### shared/smpc_pkg.sv
package smpc_pkg;
    typedef enum logic [2:0] {
        SMPC_RUN,
        SMPC_SLEEP,
        SMPC_START,
        SMPC_HALT
    } smpc_state_t;
endpackage : smpc_pkg

// ### verilog/smpc_wake_sel.sv
`timescale 1ns/1ps
`include "smpc_consts.svh"
// combines wake sources allowed by the sleep mode
module smpc_wake_sel
    import smpc_pkg::*;
(
    // mode and sources
    input wire logic [1:0] mode,
    input wire logic irq_any,
    input wire logic ext_irq_a,
    input wire logic ext_irq_b,
    input wire logic ext_a_level,
    input wire logic ext_b_level,
    input wire logic pin_change_irq,
    input wire logic two_wire_match,
    input wire logic nvm_ready_irq,
    input wire logic conv_done_irq,
    input wire logic watchdog_irq,
    // result
    output logic wake
);
    logic lvl_ext;
    logic deep_common;
    always_comb
    begin
        lvl_ext = (ext_irq_a & ext_a_level) | (ext_irq_b & ext_b_level);
        deep_common = lvl_ext | pin_change_irq | two_wire_match
            | watchdog_irq;
        case (mode)
            `SMPC_MODE_IDLE: wake = irq_any;
            `SMPC_MODE_NOISE: wake = deep_common | nvm_ready_irq
                | conv_done_irq;
            `SMPC_MODE_PDOWN: wake = deep_common;
            default: wake = 1'b0;
        endcase
    end
endmodule : smpc_wake_sel

// ### verilog/smpc_boff_seq.sv
`timescale 1ns/1ps
`include "smpc_consts.svh"
// timed unlock sequence for the brown-out sleep-off bit
module smpc_boff_seq
    import smpc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register write
    input wire logic mcr_wr,
    input wire logic [7:0] mcr_wdata,
    // state
    output logic unlock,
    output logic boff_bit,
    output logic boff_active
);
    logic [2:0] win_cnt;
    logic [2:0] age;
    logic wr_off;
    logic wr_unl;
    assign wr_off = mcr_wdata[`SMPC_MCR_BOFF_BIT];
    assign wr_unl = mcr_wdata[`SMPC_MCR_UNLOCK_BIT];
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            win_cnt <= 3'h0;
        end
        else if (mcr_wr && wr_off && wr_unl && win_cnt == 3'h0)
        begin
            win_cnt <= 3'(`SMPC_UNLOCK_WINDOW);
        end
        else if (win_cnt != 3'h0)
        begin
            win_cnt <= win_cnt - 3'h1;
        end
    end
    assign unlock = (win_cnt != 3'h0);
    // second write sets bit; self clear
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            boff_bit <= 1'b0;
            age <= 3'h0;
        end
        else if (mcr_wr && unlock && wr_off && !wr_unl)
        begin
            boff_bit <= 1'b1;
            age <= 3'h0;
        end
        else if (boff_bit)
        begin
            if (age == 3'(`SMPC_BOFF_DELAY + `SMPC_BOFF_LIFE - 1))
                boff_bit <= 1'b0;
            age <= age + 3'h1;
        end
    end
    assign boff_active = boff_bit && (age >= 3'(`SMPC_BOFF_DELAY - 1));
    unlock_window_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(unlock) |-> unlock [*4] ##1 !unlock)
        else $error("unlock window length wrong");
    boff_life_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(boff_bit) |-> boff_bit [*6] ##1 !boff_bit)
        else $error("sleep-off bit lifetime wrong");
endmodule : smpc_boff_seq

// ### verilog/smpc_ctrl.sv
`timescale 1ns/1ps
`include "smpc_consts.svh"
module smpc_ctrl
    import smpc_pkg::*;
#(
    parameter int START_CYCLES = `SMPC_START_CYCLES,
    parameter int RESET_CYCLES = `SMPC_RESET_CYCLES
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // core register writes
    input wire logic scr_wr,
    input wire logic mcr_wr,
    input wire logic [7:0] wdata,
    // core instruction and reset source
    input wire logic sleep_instr,
    input wire logic sys_reset_req,
    // fuses and converter status
    input wire logic brownout_fuse_en,
    input wire logic [15:0] start_cycles_fuse,
    input wire logic conv_enabled,
    // wake sources
    input wire logic irq_any,
    input wire logic ext_irq_a,
    input wire logic ext_irq_b,
    input wire logic ext_a_level,
    input wire logic ext_b_level,
    input wire logic pin_change_irq,
    input wire logic two_wire_match,
    input wire logic nvm_ready_irq,
    input wire logic conv_done_irq,
    input wire logic watchdog_irq,
    // register read-back
    output logic [7:0] sleep_control_reg,
    output logic [7:0] mcu_control_reg,
    // clock gates, high means clock runs
    output logic core_clock_en,
    output logic program_mem_clock_en,
    output logic peripheral_clock_en,
    output logic converter_clock_en,
    output logic oscillator_en,
    // other controls
    output logic brownout_detector_en,
    output logic conv_start,
    output logic conv_extended,
    output logic irq_service,
    output logic reset_vector,
    output logic asleep
);
    if (START_CYCLES < 1 || START_CYCLES > 65535
        || RESET_CYCLES < 1 || RESET_CYCLES > 65535)
    begin : g_bad_counts
        $error("start-up counts out of range");
    end

    smpc_state_t state;
    logic sleep_arm_bit;
    logic [1:0] sleep_mode_select;
    logic [1:0] cur_mode;
    logic unlock;
    logic boff_bit;
    logic boff_active;
    logic wake;
    logic bod_off;
    logic [15:0] cnt;
    logic conv_en_d;
    logic take_sleep;

    function automatic logic [15:0] clamp16(input int v);
        clamp16 = (v < 1) ? 16'h0001 : 16'(v);
    endfunction : clamp16

    smpc_boff_seq u_boff (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .mcr_wr(mcr_wr),
        .mcr_wdata(wdata),
        .unlock(unlock),
        .boff_bit(boff_bit),
        .boff_active(boff_active)
    );

    smpc_wake_sel u_wake (
        .mode(cur_mode),
        .irq_any(irq_any),
        .ext_irq_a(ext_irq_a),
        .ext_irq_b(ext_irq_b),
        .ext_a_level(ext_a_level),
        .ext_b_level(ext_b_level),
        .pin_change_irq(pin_change_irq),
        .two_wire_match(two_wire_match),
        .nvm_ready_irq(nvm_ready_irq),
        .conv_done_irq(conv_done_irq),
        .watchdog_irq(watchdog_irq),
        .wake(wake)
    );

    // arm bit and mode field; kept in sleep
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sleep_arm_bit <= 1'b0;
            sleep_mode_select <= 2'h0;
        end
        else if (scr_wr)
        begin
            sleep_arm_bit <= wdata[`SMPC_SCR_ARM_BIT];
            sleep_mode_select <= wdata[`SMPC_SCR_MODE_MSB:`SMPC_SCR_MODE_LSB];
        end
    end

    assign take_sleep = sleep_instr && sleep_arm_bit
        && sleep_mode_select != `SMPC_MODE_RSVD;

    // main sequence
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= SMPC_RUN;
            cur_mode <= `SMPC_MODE_IDLE;
            bod_off <= 1'b0;
            cnt <= 16'h0000;
        end
        else if (sys_reset_req)
        begin
            state <= (state == SMPC_RUN) ? SMPC_RUN : SMPC_START;
            bod_off <= 1'b0;
            cnt <= clamp16(RESET_CYCLES);
        end
        else
        begin
            case (state)
                SMPC_RUN:
                begin
                    if (take_sleep)
                    begin
                        state <= SMPC_SLEEP;
                        cur_mode <= sleep_mode_select;
                        // shut-off only in power-down when active
                        bod_off <= boff_active
                            && sleep_mode_select == `SMPC_MODE_PDOWN;
                    end
                end
                SMPC_SLEEP:
                begin
                    if (wake)
                    begin
                        state <= SMPC_START;
                        // full reset delay if detector was off
                        if (bod_off)
                            cnt <= clamp16(RESET_CYCLES);
                        else if (cur_mode == `SMPC_MODE_PDOWN)
                            cnt <= (start_cycles_fuse == 16'h0000)
                                ? 16'h0001 : start_cycles_fuse;
                        else
                            cnt <= 16'h0001;
                        bod_off <= 1'b0;
                    end
                end
                SMPC_START:
                begin
                    if (cnt <= 16'h0001)
                    begin
                        state <= SMPC_HALT;
                        cnt <= 16'(`SMPC_WAKE_HALT);
                    end
                    else
                    begin
                        cnt <= cnt - 16'h0001;
                    end
                end
                SMPC_HALT:
                begin
                    if (cnt <= 16'h0001)
                        state <= SMPC_RUN;
                    cnt <= cnt - 16'h0001;
                end
                default: state <= SMPC_RUN;
            endcase
        end
    end

    // clock gating outputs
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            core_clock_en <= 1'b1;
            program_mem_clock_en <= 1'b1;
            peripheral_clock_en <= 1'b1;
            converter_clock_en <= 1'b1;
            oscillator_en <= 1'b1;
            asleep <= 1'b0;
        end
        else if (state == SMPC_RUN && take_sleep && !sys_reset_req)
        begin
            // core and program clocks stop in every mode
            core_clock_en <= 1'b0;
            program_mem_clock_en <= 1'b0;
            // idle keeps peripheral clock; noise stops it
            peripheral_clock_en <= sleep_mode_select == `SMPC_MODE_IDLE;
            // power-down stops converter clock and oscillator
            converter_clock_en <= sleep_mode_select != `SMPC_MODE_PDOWN;
            oscillator_en <= sleep_mode_select != `SMPC_MODE_PDOWN;
            asleep <= 1'b1;
        end
        else if (state == SMPC_SLEEP && (wake || sys_reset_req))
        begin
            oscillator_en <= 1'b1;
            converter_clock_en <= 1'b1;
            peripheral_clock_en <= 1'b1;
        end
        else if (state == SMPC_HALT && cnt <= 16'h0001)
        begin
            core_clock_en <= 1'b1;
            program_mem_clock_en <= 1'b1;
            asleep <= 1'b0;
        end
    end

    // service entry pulse; reset vector pulse
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_service <= 1'b0;
            reset_vector <= 1'b0;
        end
        else
        begin
            irq_service <= state == SMPC_HALT && cnt <= 16'h0001
                && !sys_reset_req;
            reset_vector <= sys_reset_req && state != SMPC_RUN;
        end
    end

    // detector enable follows fuse and shut-off
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            brownout_detector_en <= 1'b0;
        else
            brownout_detector_en <= brownout_fuse_en
                && !(state == SMPC_SLEEP && bod_off);
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            conv_start <= 1'b0;
            conv_extended <= 1'b0;
            conv_en_d <= 1'b0;
        end
        else
        begin
            conv_en_d <= conv_enabled;
            conv_start <= state == SMPC_RUN && take_sleep && conv_enabled
                && sleep_mode_select != `SMPC_MODE_PDOWN && !sys_reset_req;
            if (conv_enabled && !conv_en_d)
                conv_extended <= 1'b1;
            else if (conv_start)
                conv_extended <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sleep_control_reg <= `SMPC_SCR_RESET;
            mcu_control_reg <= `SMPC_MCR_RESET;
        end
        else
        begin
            sleep_control_reg <= {5'h00, sleep_mode_select, sleep_arm_bit};
            mcu_control_reg <= `SMPC_MCR_RESET;
            mcu_control_reg[`SMPC_MCR_BOFF_BIT] <= boff_bit;
            mcu_control_reg[`SMPC_MCR_UNLOCK_BIT] <= unlock;
        end
    end

    sequence entry_s;
        state == SMPC_RUN && take_sleep && !sys_reset_req;
    endsequence

    sequence halt_s;
        state == SMPC_HALT [*4];
    endsequence

    sleep_entry_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        entry_s |=> state == SMPC_SLEEP && !core_clock_en)
        else $error("armed sleep not entered");
    unarmed_noop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        state == SMPC_RUN && sleep_instr && !take_sleep
        |=> state == SMPC_RUN && core_clock_en)
        else $error("unarmed sleep gated clocks");
    wake_halt_a: assert property (@(posedge sys_clk)
        disable iff (!rstn || sys_reset_req)
        $rose(state == SMPC_HALT) |-> halt_s ##1 state == SMPC_RUN)
        else $error("halt length wrong");
    idle_gating_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (entry_s and (sleep_mode_select == `SMPC_MODE_IDLE))
        |=> peripheral_clock_en && converter_clock_en && oscillator_en)
        else $error("idle gating wrong");
    noise_gating_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (entry_s and (sleep_mode_select == `SMPC_MODE_NOISE))
        |=> !peripheral_clock_en && converter_clock_en)
        else $error("noise gating wrong");
    pdown_gating_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (entry_s and (sleep_mode_select == `SMPC_MODE_PDOWN))
        |=> !oscillator_en && !converter_clock_en)
        else $error("power-down gating wrong");
    conv_auto_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (entry_s and (conv_enabled && sleep_mode_select != `SMPC_MODE_PDOWN))
        |=> conv_start)
        else $error("no auto conversion");
    // reset in sleep goes to reset vector
    reset_wake_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        state == SMPC_SLEEP && sys_reset_req |=> reset_vector)
        else $error("reset did not reach vector");
    // detector off only when shut off in sleep
    bod_sleep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        brownout_fuse_en && state == SMPC_SLEEP && !bod_off
        |=> brownout_detector_en)
        else $error("detector dropped in sleep");
endmodule : smpc_ctrl

// ### verification/smpc_core_model.sv
`timescale 1ns/1ps
// core side: control register writes and the sleep instruction
module smpc_core_model
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register writes and instruction
    output logic scr_wr,
    output logic mcr_wr,
    output logic [7:0] wdata,
    output logic sleep_instr
);
    logic busy = 1'b0;
    logic [7:0] hold = 8'h00;
    logic [7:0] churn = 8'hA5;

    // the data bus keeps moving when no write is in flight
    assign wdata = busy ? hold : churn;

    initial
    begin
        scr_wr = 1'b0;
        mcr_wr = 1'b0;
        sleep_instr = 1'b0;
    end

    always @(posedge sys_clk)
    begin
        churn <= churn + 8'h5B;
    end

    task automatic bus_write(input logic sel, input logic [7:0] d);
        @(posedge sys_clk);
        busy <= 1'b1;
        hold <= d;
        if (sel)
            mcr_wr <= 1'b1;
        else
            scr_wr <= 1'b1;
        @(posedge sys_clk);
        busy <= 1'b0;
        mcr_wr <= 1'b0;
        scr_wr <= 1'b0;
    endtask : bus_write

    task automatic write_scr(input logic [7:0] d);
        bus_write(1'b0, d);
    endtask : write_scr

    task automatic write_mcr(input logic [7:0] d);
        bus_write(1'b1, d);
    endtask : write_mcr

    task automatic do_sleep;
        @(posedge sys_clk);
        sleep_instr <= 1'b1;
        @(posedge sys_clk);
        sleep_instr <= 1'b0;
    endtask : do_sleep

    task automatic boff_arm;
        write_mcr(8'h60);
        write_mcr(8'h40);
    endtask : boff_arm

    task automatic boff_sleep;
        boff_arm();
        repeat (2) @(posedge sys_clk);
        do_sleep();
    endtask : boff_sleep
endmodule : smpc_core_model

// ### verification/tb.sv
`timescale 1ns/1ps
`include "smpc_consts.svh"
module tb
    import smpc_pkg::*;
;
    localparam int RST = 4;
    localparam logic [2:0] EV_CONV = 3'h4;
    localparam logic [2:0] EV_RST = 3'h2;
    localparam logic [2:0] EV_IRQ = 3'h1;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic sys_reset_req = 1'b0;
    logic bod_fuse = 1'b1;
    logic conv_en = 1'b1;
    logic lvl_a = 1'b1;
    logic lvl_b = 1'b0;
    logic [15:0] start_fuse = 16'h0008;
    logic [7:0] src = 8'h00;
    logic scr_wr, mcr_wr, sleep_instr;
    logic [7:0] wdata, scr_q, mcr_q;
    logic core_en, pm_en, per_en, cv_en, osc_en, bod_en;
    logic conv_start, conv_ext, irq_service, reset_vector, asleep;
    logic [2:0] evq[$];
    logic ign_irq = 1'b0;
    logic [7:0] ng [6] = '{8'h02, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
    logic [7:0] pg [4] = '{8'h02, 8'h08, 8'h10, 8'h80};
    int cyc = 0;
    int last_irq = 0;
    int n_errors = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'hC62DC0FC;

    always #12.5 sys_clk = ~sys_clk;

    smpc_core_model core_u (.sys_clk(sys_clk), .rstn(rstn),
        .scr_wr(scr_wr), .mcr_wr(mcr_wr), .wdata(wdata),
        .sleep_instr(sleep_instr));

    smpc_ctrl #(.RESET_CYCLES(RST)) dut_u (.sys_clk(sys_clk), .rstn(rstn),
        .scr_wr(scr_wr), .mcr_wr(mcr_wr), .wdata(wdata),
        .sleep_instr(sleep_instr), .sys_reset_req(sys_reset_req),
        .brownout_fuse_en(bod_fuse), .start_cycles_fuse(start_fuse),
        .conv_enabled(conv_en), .irq_any(src[0]), .ext_irq_a(src[1]),
        .ext_irq_b(src[2]), .ext_a_level(lvl_a), .ext_b_level(lvl_b),
        .pin_change_irq(src[3]), .two_wire_match(src[4]),
        .nvm_ready_irq(src[5]), .conv_done_irq(src[6]),
        .watchdog_irq(src[7]), .sleep_control_reg(scr_q),
        .mcu_control_reg(mcr_q), .core_clock_en(core_en),
        .program_mem_clock_en(pm_en), .peripheral_clock_en(per_en),
        .converter_clock_en(cv_en), .oscillator_en(osc_en),
        .brownout_detector_en(bod_en), .conv_start(conv_start),
        .conv_extended(conv_ext), .irq_service(irq_service),
        .reset_vector(reset_vector), .asleep(asleep));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xorshift

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // result watcher: each pulse takes the oldest note, save irq_service pulses while ign_irq is set
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (rstn && (conv_start || reset_vector || (irq_service && !ign_irq)))
        begin
            if (irq_service)
                last_irq <= cyc;
            check({conv_start, reset_vector, irq_service && !ign_irq},
                evq.size() > 0 ? evq.pop_front() : 3'h0);
        end
    end

    task automatic wait_awake;
        int n;
        n = 0;
        while (asleep !== 1'b0 && n < 400)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(asleep, 1'b0);
    endtask : wait_awake

    task automatic run_mode(input logic [1:0] mode, input logic [7:0] bad,
        input logic [7:0] good, input int nstart, input logic boff,
        input logic [4:0] gates);
        int t0;
        int lat;
        core_u.write_scr({5'h00, mode, 1'b1});
        if (conv_en && mode != `SMPC_MODE_PDOWN)
            evq.push_back(EV_CONV);
        evq.push_back(EV_IRQ);
        if (boff)
            core_u.boff_sleep();
        else
            core_u.do_sleep();
        @(posedge sys_clk);
        #1;
        check(asleep, 1'b1);
        check({core_en, pm_en, per_en, cv_en, osc_en}, gates);
        check(bod_en, !(boff && mode == `SMPC_MODE_PDOWN));
        seed = xorshift(seed);
        @(posedge sys_clk);
        src <= bad & (seed[7:0] | 8'h01);
        repeat (8) @(posedge sys_clk);
        #1;
        check(asleep, 1'b1);
        @(posedge sys_clk);
        src <= good;
        t0 = cyc + 1;
        wait_awake();
        @(posedge sys_clk);
        src <= 8'h00;
        repeat (2) @(posedge sys_clk);
        #1;
        lat = last_irq - t0;
        check(lat >= nstart + 4 && lat <= nstart + 7, 1'b1);
        check({core_en, pm_en, per_en, cv_en, osc_en}, 5'h1F);
        check(bod_en, 1'b1);
        check(scr_q, {5'h00, mode, 1'b1});
    endtask : run_mode

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        print_verdict();
    end

    initial
    begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        #1;
        check(scr_q, `SMPC_SCR_RESET);
        check(mcr_q, `SMPC_MCR_RESET);
        seed = xorshift(seed);
        @(posedge sys_clk);
        start_fuse <= 16'h0004 + {13'h0000, seed[2:0]};
        conv_en <= 1'b0;
        @(posedge sys_clk);
        conv_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check(conv_ext, 1'b1);
        run_mode(`SMPC_MODE_IDLE, 8'h00, 8'h01, 1, 1'b0, 5'b00111);
        check(conv_ext, 1'b0);
        for (int i = 0; i < 6; i++)
            run_mode(`SMPC_MODE_NOISE, 8'h05, ng[i], 1, 1'b0, 5'b00011);
        for (int i = 0; i < 4; i++)
            run_mode(`SMPC_MODE_PDOWN, 8'h65, pg[i], int'(start_fuse), 1'b0,
                5'b00000);
        core_u.write_mcr(8'h40);
        @(posedge sys_clk);
        #1;
        check(mcr_q[6], 1'b0);
        core_u.boff_arm();
        @(posedge sys_clk);
        #1;
        check(mcr_q[6], 1'b1);
        check(mcr_q[5], 1'b1);
        repeat (10) @(posedge sys_clk);
        #1;
        check(mcr_q[6], 1'b0);
        check(mcr_q[5], 1'b0);
        run_mode(`SMPC_MODE_PDOWN, 8'h65, 8'h08, RST, 1'b1, 5'b00000);
        for (int i = 0; i < 2; i++)
        begin
            core_u.write_scr(i ? 8'h04 : 8'h07);
            core_u.do_sleep();
            repeat (3) @(posedge sys_clk);
            #1;
            check({asleep, core_en}, 2'b01);
        end
        core_u.write_scr(8'h01);
        evq.push_back(EV_CONV);
        evq.push_back(EV_RST);
        ign_irq = 1'b1;
        core_u.do_sleep();
        @(posedge sys_clk);
        sys_reset_req <= 1'b1;
        @(posedge sys_clk);
        sys_reset_req <= 1'b0;
        wait_awake();
        repeat (2) @(posedge sys_clk);
        #1;
        check(evq.size(), 0);
        ign_irq = 1'b0;
        print_verdict();
    end
endmodule : tb
